// File: design/single_wire_master.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
module single_wire_master (
   input  wire logic                              CORE_CLK,
   input  wire logic                              RST_N,
   input  wire logic                              CLK_EN,
   input  wire logic [single_wire_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [single_wire_pkg::DATA_W-1:0] WDATA,
   input  wire logic                              WR,
   input  wire logic                              RD,
   output logic      [single_wire_pkg::DATA_W-1:0] RDATA,
   input  wire logic                              BUS_LINE_I,
   output logic                                   BUS_LINE_O,
   output logic                                   BUS_LINE_OE,
   output logic                                   STRONG_PULLUP_ENABLE_N
);
   import single_wire_pkg::*;

   state_e              state_q, state_d;
   logic [CNT_W-1:0]    cnt_q, cnt_d;
   logic [CNT_W-1:0]    spu_cnt_q, spu_cnt_d;
   logic [CNT_W-1:0]    spu_len_q, spu_len_d;
   logic                spu_pend_q, spu_pend_d;
   logic                spu_hold_q, spu_hold_d;
   logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
   logic                go_rst_q, go_rst_d;
   logic                go_byte_q, go_byte_d;
   logic [DATA_W-1:0]   sh_q, sh_d;
   logic [DATA_W-1:0]   rx_q, rx_d;
   logic [2:0]          bit_q, bit_d;
   logic                pres_q, pres_d;
   logic                absent_q, absent_d;
   logic                oe_q, oe_d;
   logic                spu_n_q, spu_n_d;
   logic [DATA_W-1:0]   rdata_q, rdata_d;
   logic                sync1_q, line_s_q;
   logic                tick, od, lng, busy, pmm_act;
   logic [CNT_W-1:0]    off1_len, rstl_len, rsth_len, pds_len, pdh_len;
   logic [CNT_W-1:0]    slot_len, low_len, rdv_len, boff_len, pmm_len;
   logic [CNT_W-1:0]    on1_len, on2_len, wr_on_len;
   logic [CNT_W-1:0]    on1_at, on2_at, wr_spu_at;

   function automatic logic [CNT_W-1:0] tk(input logic sel_od,
                                            input int   std_ns,
                                            input int   od_ns);
      tk = sel_od ? CNT_W'(od_ns / OD_TICK_NS)
                  : CNT_W'(std_ns / STD_TICK_NS);
   endfunction

   single_wire_tick #(
      .STD_DIV (STD_DIV),
      .OD_DIV  (OD_DIV),
      .DIV_W   (8)
   ) u_tick (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .ce    (CLK_EN),
      .od    (od),
      .tick  (tick)
   );

   assign od      = ctrl_q[CTRL_OD];
   assign lng     = ctrl_q[CTRL_LONG] & ~od;
   assign pmm_act = ctrl_q[CTRL_PMM] & ~od;
   assign busy    = (state_q != ST_IDLE) | go_rst_q | go_byte_q;

   // Phase lengths in ticks for the selected speed
   assign off1_len = tk(od, OFF1_NS, OFF1_NS);                      // R19
   assign rstl_len = tk(od, RSTL_STD_NS, RSTL_OD_NS);               // R1
   assign rsth_len = tk(od, RSTH_STD_NS, RSTH_OD_NS);               // R2
   assign pds_len  = tk(od, lng ? PDS_LONG_NS : PDS_STD_NS,
                        PDS_OD_NS);                                 // R5
   assign pdh_len  = tk(od, PDH_STD_NS, PDH_OD_NS);                 // R6
   assign slot_len = tk(od, SLOT_STD_NS, SLOT_OD_NS);               // R7
   assign low_len  = sh_q[0] ? tk(od, lng ? LOW1_LONG_NS : LOW1_STD_NS,
                                  LOW1_OD_NS)                       // R8
                             : tk(od, LOW0_STD_NS, LOW0_OD_NS);     // R9
   assign rdv_len  = tk(od, lng ? RDV_LONG_NS : RDV_STD_NS,
                        RDV_OD_NS);                                 // R11
   assign boff_len = (bit_q == 3'h0) ? tk(od, FIRST_OFF_NS,
                                          FIRST_OFF_NS)             // R20
                                     : tk(od, OFF2_NS, OFF2_NS);    // R19
   assign pmm_len  = tk(od, PMM_START_NS, PMM_START_NS);            // R12
   assign on1_len  = tk(od, ON1_STD_NS, ON1_OD_NS);                 // R13
   assign on2_len  = tk(od, ON2_NS, ON2_NS);                        // R13
   assign wr_on_len = sh_q[0] ? tk(od, ON3_STD_NS, ON3_OD_NS)       // R14
                              : tk(od, ON4_STD_NS, ON4_OD_NS);      // R15
   assign on1_at   = pds_len + tk(od, DLY1_NS, DLY1_NS);            // R19
   assign on2_at   = pds_len + tk(od, DLY2_STD_NS, DLY2_OD_NS);     // R16
   assign wr_spu_at = low_len + tk(od, DLY3_NS, DLY3_NS);           // R19

   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      spu_cnt_d  = spu_cnt_q;
      spu_len_d  = spu_len_q;
      spu_pend_d = spu_pend_q;
      spu_hold_d = spu_hold_q;
      ctrl_d     = ctrl_q;
      go_rst_d   = go_rst_q;
      go_byte_d  = go_byte_q;
      sh_d       = sh_q;
      rx_d       = rx_q;
      bit_d      = bit_q;
      pres_d     = pres_q;
      absent_d   = absent_q;
      rdata_d    = '0;

      // Commands and data are refused while a sequence is running
      if (WR) begin
         unique case (ADDR)
            REG_CTRL: ctrl_d = WDATA[CTRL_W-1:0];
            REG_CMD: begin
               if (!busy) begin
                  go_rst_d  = WDATA[CMD_RESET];
                  go_byte_d = WDATA[CMD_BYTE];
               end
            end
            REG_DATA: begin
               if (!busy) sh_d = WDATA;
            end
            default: ;
         endcase
      end
      if (RD) begin
         unique case (ADDR)
            REG_CTRL:   rdata_d = {2'h0, ctrl_q};
            REG_DATA:   rdata_d = rx_q;
            REG_STATUS: rdata_d = {5'h00, absent_q, pres_q, busy};
            default:    rdata_d = '0;
         endcase
      end

      if (tick) begin
         if (spu_cnt_q != '0) spu_cnt_d = spu_cnt_q - CNT_W'(1);
         if (spu_pend_q && line_s_q) begin
            spu_pend_d = 1'b0;                                      // R17
            spu_cnt_d  = spu_len_q;
         end
         cnt_d = cnt_q + CNT_W'(1);
         unique case (state_q)
            ST_IDLE: begin
               cnt_d = '0;
               if (go_rst_q) begin
                  go_rst_d = 1'b0;
                  pres_d   = 1'b0;
                  absent_d = 1'b0;
                  state_d  = ST_RST_OFF;
               end else if (go_byte_q) begin
                  go_byte_d = 1'b0;
                  bit_d     = 3'h0;
                  state_d   = ST_BIT_OFF;
               end
            end
            ST_RST_OFF: begin
               if (cnt_q == off1_len - CNT_W'(1)) begin             // R19
                  cnt_d   = '0;
                  state_d = ST_RST_LOW;
               end
            end
            ST_RST_LOW: begin
               if (cnt_q == rstl_len - CNT_W'(1)) begin             // R1
                  cnt_d   = '0;
                  state_d = ST_RST_HIGH;
               end
            end
            ST_RST_HIGH: begin
               if (cnt_q == pds_len) pres_d = ~line_s_q;            // R5
               if (cnt_q == pdh_len && !pres_q) absent_d = 1'b1;    // R6
               if (cnt_q == on1_at) spu_cnt_d = on1_len;            // R13
               if (cnt_q == on2_at) begin
                  spu_pend_d = 1'b1;                                // R16
                  spu_len_d  = on2_len;
               end
               if (cnt_q == rsth_len - CNT_W'(1)) begin             // R2
                  cnt_d   = '0;
                  state_d = ST_IDLE;
               end
            end
            ST_BIT_OFF: begin
               if (cnt_q == boff_len - CNT_W'(1)) begin             // R20
                  cnt_d   = '0;
                  state_d = ST_BIT_SLOT;
               end
            end
            ST_BIT_SLOT: begin
               if (cnt_q == rdv_len) rx_d = {line_s_q, rx_q[7:1]};  // R11
               if (cnt_q == wr_spu_at - CNT_W'(1)) begin
                  if (ctrl_q[CTRL_READ]) begin
                     spu_pend_d = 1'b1;                             // R17
                     spu_len_d  = wr_on_len;
                  end else begin
                     spu_cnt_d = wr_on_len;                         // R14
                  end
               end
               if (cnt_q == slot_len - CNT_W'(1)) begin             // R7
                  cnt_d = '0;
                  sh_d  = {1'b0, sh_q[7:1]};
                  if (bit_q == 3'h7) begin
                     spu_hold_d = ctrl_q[CTRL_HOLD];                // R18
                     state_d    = ST_IDLE;
                  end else begin
                     bit_d   = bit_q + 3'h1;
                     state_d = ST_BIT_OFF;
                  end
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end

      // Pullup is forced off ahead of every reset and slot
      if (state_d == ST_RST_OFF || state_d == ST_BIT_OFF) begin
         spu_cnt_d  = '0;                                           // R19
         spu_pend_d = 1'b0;
         spu_hold_d = 1'b0;
      end

      oe_d = (state_d == ST_RST_LOW)                                // R1
           | (state_d == ST_BIT_SLOT && cnt_d < low_len)            // R8
           | (state_d == ST_RST_HIGH && pmm_act                     // R12
              && cnt_d >= pmm_len && cnt_d < pdh_len);
      spu_n_d = ~(ctrl_q[CTRL_SPU]
                  & ((spu_cnt_d != '0) | spu_hold_d));
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         state_q    <= ST_IDLE;
         cnt_q      <= '0;
         spu_cnt_q  <= '0;
         spu_len_q  <= '0;
         spu_pend_q <= 1'b0;
         spu_hold_q <= 1'b0;
         ctrl_q     <= CTRL_RESET;
         go_rst_q   <= 1'b0;
         go_byte_q  <= 1'b0;
         sh_q       <= DATA_RESET;
         rx_q       <= DATA_RESET;
         bit_q      <= 3'h0;
         pres_q     <= 1'b0;
         absent_q   <= 1'b0;
         oe_q       <= 1'b0;
         spu_n_q    <= 1'b1;
         rdata_q    <= DATA_RESET;
         sync1_q    <= 1'b1;
         line_s_q   <= 1'b1;
      end else if (CLK_EN) begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         spu_cnt_q  <= spu_cnt_d;
         spu_len_q  <= spu_len_d;
         spu_pend_q <= spu_pend_d;
         spu_hold_q <= spu_hold_d;
         ctrl_q     <= ctrl_d;
         go_rst_q   <= go_rst_d;
         go_byte_q  <= go_byte_d;
         sh_q       <= sh_d;
         rx_q       <= rx_d;
         bit_q      <= bit_d;
         pres_q     <= pres_d;
         absent_q   <= absent_d;
         oe_q       <= oe_d;
         spu_n_q    <= spu_n_d;
         rdata_q    <= rdata_d;
         sync1_q    <= BUS_LINE_I;
         line_s_q   <= sync1_q;
      end
   end

   assign RDATA                  = rdata_q;
   assign BUS_LINE_O             = 1'b0;
   assign BUS_LINE_OE            = oe_q;
   assign STRONG_PULLUP_ENABLE_N = spu_n_q;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   a_reset_drives_low: assert property (                            // R1
      state_q == ST_RST_LOW |-> BUS_LINE_OE)
      else $error("Line not driven low during reset pulse");
   a_reset_low_len: assert property (                               // R1
      state_q == ST_RST_HIGH && $past(state_q) == ST_RST_LOW
      |-> $past(cnt_q) == $past(rstl_len) - CNT_W'(1))
      else $error("Reset pulse length wrong");
   a_recovery_free: assert property (                               // R2
      state_q == ST_RST_HIGH && !pmm_act |-> !BUS_LINE_OE)
      else $error("Line driven during reset recovery");
   a_presence_sample: assert property (                             // R5
      $rose(pres_q) |-> $past(state_q) == ST_RST_HIGH
                        && $past(cnt_q) == $past(pds_len))
      else $error("Presence sampled at wrong time");
   a_slot_len: assert property (                                    // R7
      state_q == ST_BIT_OFF && $past(state_q) == ST_BIT_SLOT
      |-> $past(cnt_q) == $past(slot_len) - CNT_W'(1))
      else $error("Time slot length wrong");
   a_write_release: assert property (                               // R8
      state_q == ST_BIT_SLOT && cnt_q >= low_len |-> !BUS_LINE_OE)
      else $error("Line still driven after bit low time");
   a_spu_off_reset: assert property (                               // R19
      state_q == ST_RST_OFF |-> STRONG_PULLUP_ENABLE_N)
      else $error("Pullup active before reset pulse");
   a_spu_off_slot: assert property (                                // R20
      state_q == ST_BIT_OFF |-> STRONG_PULLUP_ENABLE_N)
      else $error("Pullup active before time slot");
   a_read_waits_high: assert property (                             // R17
      spu_pend_q && !line_s_q && !spu_hold_q && spu_cnt_q == '0
      && CLK_EN |=> STRONG_PULLUP_ENABLE_N)
      else $error("Pullup enabled before line seen high");

   c_presence: cover property ($rose(pres_q));
   c_absent:   cover property ($rose(absent_q));
   c_byte_end: cover property (state_q == ST_BIT_SLOT ##1
                               state_q == ST_IDLE);
   c_spu_on:   cover property ($fell(STRONG_PULLUP_ENABLE_N));
endmodule

// File: design/single_wire_pkg.sv
// How it works
// [R1] Reset pulse holds the line low 512 us standard/long, 55 us overdrive.
// [R2] Line then stays released 520 us standard/long, 65 us overdrive.
// [R3] Slaves start presence 15-60 us (2-6 us overdrive) after release.
// [R4] Slave presence pulse lasts 60-240 us, or 8-24 us overdrive.
// [R5] Presence is sampled 28 us, 3 us overdrive, 34 us long-line after release.
// [R6] No low by 64 us (7 us overdrive) after release flags an absent slave.
// [R7] Every bit slot lasts 80 us standard/long, 13 us overdrive.
// [R8] A one is driven low 5 us, 0.9 us overdrive, 8 us long-line.
// [R9] A zero is driven low 64 us, or 9 us overdrive.
// [R10] Slaves sample the written bit 15-60 us (2-6, 25-60) into the slot.
// [R11] Read level is sampled 13 us, 1.8 us overdrive, 22 us long-line in.
// [R12] Presence-mask mode drives the line low from 15 us after release, standard/long only.
// [R13] Pullup on 7 us (0.9 od) after presence, 9 us after recovery.
// [R14] After a written one pullup stays on 56 us, 8 us overdrive.
// [R15] After a written zero pullup stays on 7 us, 0.9 us overdrive.
// [R16] 400 us (35 od) after presence, pullup waits for a high line.
// [R17] Read slots enable pullup only once a tick sees the line high.
// [R18] After the last bit, pullup holds until the next reset or byte starts; it has no timeout.
// [R19] Pullup off 2 us before reset, 1 us before slots; 1 us delays.
// [R20] First bit of a byte gets a 4 us pullup turn-off time.
// [R21] A clock divider makes the 1 us or 50 ns state tick.
package single_wire_pkg;

   localparam int CLK_PERIOD_NS = 5;
   localparam int STD_TICK_NS   = 1000;
   localparam int OD_TICK_NS    = 50;
   localparam int STD_DIV       = STD_TICK_NS / CLK_PERIOD_NS;
   localparam int OD_DIV        = OD_TICK_NS / CLK_PERIOD_NS;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 11;

   localparam logic [ADDR_W-1:0] REG_CTRL   = 3'h0;
   localparam logic [ADDR_W-1:0] REG_CMD    = 3'h1;
   localparam logic [ADDR_W-1:0] REG_DATA   = 3'h2;
   localparam logic [ADDR_W-1:0] REG_STATUS = 3'h3;

   localparam int CTRL_W    = 6;
   localparam int CTRL_OD   = 0;
   localparam int CTRL_LONG = 1;
   localparam int CTRL_PMM  = 2;
   localparam int CTRL_SPU  = 3;
   localparam int CTRL_HOLD = 4;
   localparam int CTRL_READ = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

   localparam int CMD_RESET = 0;
   localparam int CMD_BYTE  = 1;

   localparam int STAT_BUSY   = 0;
   localparam int STAT_PRES   = 1;
   localparam int STAT_ABSENT = 2;

   localparam int RSTL_STD_NS   = 512000;
   localparam int RSTL_OD_NS    = 55000;
   localparam int RSTH_STD_NS   = 520000;
   localparam int RSTH_OD_NS    = 65000;
   localparam int PDS_STD_NS    = 28000;
   localparam int PDS_LONG_NS   = 34000;
   localparam int PDS_OD_NS     = 3000;
   localparam int PDH_STD_NS    = 64000;
   localparam int PDH_OD_NS     = 7000;
   localparam int SLOT_STD_NS   = 80000;
   localparam int SLOT_OD_NS    = 13000;
   localparam int LOW1_STD_NS   = 5000;
   localparam int LOW1_LONG_NS  = 8000;
   localparam int LOW1_OD_NS    = 900;
   localparam int LOW0_STD_NS   = 64000;
   localparam int LOW0_OD_NS    = 9000;
   localparam int RDV_STD_NS    = 13000;
   localparam int RDV_LONG_NS   = 22000;
   localparam int RDV_OD_NS     = 1800;
   localparam int PMM_START_NS  = 15000;
   localparam int ON1_STD_NS    = 7000;
   localparam int ON1_OD_NS     = 900;
   localparam int ON2_NS        = 9000;
   localparam int ON3_STD_NS    = 56000;
   localparam int ON3_OD_NS     = 8000;
   localparam int ON4_STD_NS    = 7000;
   localparam int ON4_OD_NS     = 900;
   localparam int DLY1_NS       = 1000;
   localparam int DLY2_STD_NS   = 400000;
   localparam int DLY2_OD_NS    = 35000;
   localparam int DLY3_NS       = 1000;
   localparam int OFF1_NS       = 2000;
   localparam int OFF2_NS       = 1000;
   localparam int FIRST_OFF_NS  = 4000;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_RST_OFF  = 3'h1,
      ST_RST_LOW  = 3'h2,
      ST_RST_HIGH = 3'h3,
      ST_BIT_OFF  = 3'h4,
      ST_BIT_SLOT = 3'h5
   } state_e;

endpackage

// File: design/single_wire_tick.sv
`timescale 1ns/1ps
module single_wire_tick #(
   parameter int STD_DIV = 200,
   parameter int OD_DIV  = 10,
   parameter int DIV_W   = 8
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic od,
   output logic      tick
);
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic             tick_d;
   logic [DIV_W-1:0] last;

   // Divides the core clock into the state tick of the selected speed
   always_comb begin
      last   = od ? DIV_W'(OD_DIV - 1) : DIV_W'(STD_DIV - 1); // R21
      tick_d = (div_q >= last);
      div_d  = tick_d ? '0 : div_q + DIV_W'(1);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_q <= '0;
         tick  <= 1'b0;
      end else if (ce) begin
         div_q <= div_d;
         tick  <= tick_d;
      end
   end
endmodule

// File: verification/single_wire_master_tb_top.sv
`timescale 1ns/1ps
module single_wire_master_tb_top;
   import single_wire_pkg::*;

   logic              core_clk  = 1'b0;
   logic              rst_n     = 1'b0;
   logic              clk_en    = 1'b1;
   logic [ADDR_W-1:0] addr      = '0;
   logic [DATA_W-1:0] wdata     = '0;
   logic              wr_s      = 1'b0;
   logic              rd_s      = 1'b0;
   logic              present   = 1'b1;
   logic [7:0]        reply     = 8'hFF;
   wire  [DATA_W-1:0] rdata;
   wire               oe;
   wire               spu_n;
   wire               line_o;
   wire               pull_low;
   wire  [7:0]        got;
   wire               bus_line  = !(oe || pull_low);
   int                bad_count = 0;
   int                n_checks  = 0;
   int                lowline   = 0;
   int                overlap   = 0;
   logic              have_on   = 1'b0;
   realtime           t_oe_on, t_oe_off, t_spu_on, t_spu_off;
   realtime           t_first, t_idle, t_cmd, offgap;
   real               oe_q[$];
   real               gap_q[$];
   real               spu_q[$];

   always #2.5 core_clk = !core_clk;

   single_wire_master dut_u (
      .CORE_CLK               (core_clk),
      .RST_N                  (rst_n),
      .CLK_EN                 (clk_en),
      .ADDR                   (addr),
      .WDATA                  (wdata),
      .WR                     (wr_s),
      .RD                     (rd_s),
      .RDATA                  (rdata),
      .BUS_LINE_I             (bus_line),
      .BUS_LINE_O             (line_o),
      .BUS_LINE_OE            (oe),
      .STRONG_PULLUP_ENABLE_N (spu_n)
   );

   single_wire_slave_model slave_u (
      .line     (bus_line),
      .present  (present),
      .reply    (reply),
      .pull_low (pull_low),
      .got      (got)
   );

   // Wire monitors: low pulse widths, fall-to-fall gaps, pullup windows
   always @(posedge oe) begin
      if (have_on) gap_q.push_back($realtime - t_oe_on);
      else t_first = $realtime;
      have_on = 1'b1;
      t_oe_on = $realtime;
      offgap  = $realtime - t_spu_off;
   end
   always @(negedge oe) begin
      t_oe_off = $realtime;
      oe_q.push_back($realtime - t_oe_on);
   end
   always @(negedge spu_n) begin
      t_spu_on = $realtime;
      if (bus_line !== 1'b1) lowline++;
   end
   always @(posedge spu_n) begin
      t_spu_off = $realtime;
      spu_q.push_back($realtime - t_spu_on);
   end
   always @(posedge core_clk) if (oe === 1'b1 && spu_n === 1'b0) overlap++;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] inr(real v, real lo, real hi);
      return (v >= lo * 1000.0 && v <= hi * 1000.0) ? 32'h1 : 32'h0;
   endfunction

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge core_clk);
      wr_s  <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge core_clk);
      rd_s <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic clr();
      oe_q.delete();
      gap_q.delete();
      spu_q.delete();
      have_on = 1'b0;
      lowline = 0;
      overlap = 0;
   endtask

   task automatic wait_idle(output logic [DATA_W-1:0] st);
      int n;
      n = 0;
      rd(REG_STATUS, st);
      while (st[STAT_BUSY] !== 1'b0 && n < 1200) begin
         repeat (20) @(posedge core_clk);
         rd(REG_STATUS, st);
         n++;
      end
      check(st[STAT_BUSY], 1'b0);
      t_idle = $realtime;
   endtask

   task automatic t_regs();
      logic [DATA_W-1:0] d;
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), d);
         check(d, 8'h00);
      end
      wr(REG_CTRL, 8'hFF);
      rd(REG_CTRL, d);
      check(d, 8'h3F);
      // A frozen core must ignore a write
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(REG_CTRL, 8'h00);
      clk_en <= 1'b1;
      rd(REG_CTRL, d);
      check(d, 8'h3F);
      wr(3'h6, 8'hFF);
      rd(3'h6, d);
      check(d, 8'h00);
      wr(REG_CTRL, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_reset_present();
      logic [DATA_W-1:0] st;
      clr();
      wr(REG_CTRL, 8'h09);
      wr(REG_CMD, 8'h01);
      rd(REG_STATUS, st);
      check(st[STAT_BUSY], 1'b1);
      wait_idle(st);
      check(st, 8'h02);
      check(oe_q.size(), 1);
      check(inr(oe_q[0], 50.4, 63.0), 1);
      check(inr(t_idle - t_oe_off, 59.2, 74.2), 1);
      check(spu_q.size(), 2);
      check(inr(spu_q[0], 0.8, 1.0), 1);
      check(inr(spu_q[1], 8.0, 10.0), 1);
      check(overlap, 0);
      check(line_o, 1'b0);
      $display("test reset with presence done");
   endtask

   task automatic t_write();
      logic [DATA_W-1:0] st;
      logic [7:0]        b;
      logic              one;
      b = 8'hA5;
      clr();
      wr(REG_CTRL, 8'h09);
      wr(REG_DATA, b);
      wr(REG_CMD, 8'h02);
      t_cmd = $realtime;
      // Refused while busy: the byte on the wire must stay intact
      wr(REG_DATA, 8'h00);
      wait_idle(st);
      check(got, b);
      check(inr(t_first - t_cmd, 3.9, 4.3), 1);
      check(oe_q.size(), 8);
      check(spu_q.size(), 8);
      for (int i = 0; i < 8; i++) begin
         one = b[i];
         check(inr(oe_q[i], one ? 0.8 : 8.0, one ? 1.0 : 10.0), 1);
         check(inr(spu_q[i], one ? 7.2 : 0.8, one ? 9.0 : 1.0), 1);
         if (i > 0) check(inr(gap_q[i-1], 12.0, 15.0), 1);
      end
      check(overlap, 0);
      $display("test write byte done");
   endtask

   task automatic t_read_hold();
      logic [DATA_W-1:0] st;
      clr();
      reply = 8'h3C;
      wr(REG_CTRL, 8'h39);
      // Read slots are sent as written ones so the slave can answer
      wr(REG_DATA, 8'hFF);
      wr(REG_CMD, 8'h02);
      wait_idle(st);
      rd(REG_DATA, st);
      check(st, 8'h3C);
      check(lowline, 0);
      check(overlap, 0);
      check(spu_n, 1'b0);
      present = 1'b0;
      wr(REG_CMD, 8'h01);
      wait_idle(st);
      check(st, 8'h04);
      check(inr(offgap, 1.6, 2.05), 1);
      $display("test read, hold and absent done");
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs();
      t_reset_present();
      t_write();
      t_read_hold();
      give_verdict();
   end

   initial begin
      #500000;
      bad_count++;
      give_verdict();
   end
endmodule

// File: verification/single_wire_slave_model.sv
`timescale 1ns/1ps
module single_wire_slave_model (
   input  wire logic       line,
   input  wire logic       present,
   input  wire logic [7:0] reply,
   output logic            pull_low,
   output logic [7:0]      got
);
   realtime t_fall;
   int      nbit;

   // A rise after a long low is a bus reset: answer with a presence pulse.
   // A master fall opens a slot: hold low for a zero reply, sample at 3 us.
   // Edges made while a pulse is under way are not seen on purpose.
   initial begin
      pull_low = 1'b0;
      got      = 8'h00;
      nbit     = 0;
      t_fall   = 0.0;
      forever begin
         @(posedge line or negedge line);
         if (line === 1'b1) begin
            if (present && ($realtime - t_fall > 40000.0)) begin
               nbit = 0;
               #2000;
               pull_low = 1'b1;
               t_fall   = $realtime;
               #15000;
               pull_low = 1'b0;
            end
         end else if (line === 1'b0) begin
            t_fall = $realtime;
            if (present) begin
               pull_low = !reply[nbit];
               #3000;
               got[nbit] = line;
               #1000;
               pull_low = 1'b0;
               nbit     = (nbit + 1) % 8;
            end
         end
      end
   end
endmodule
